// ### logic/bcp_pkg.sv
// shared constants of the brushless commutation and protection core
package bcp_pkg;

  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned TACH_TIME_NS = 5000;
  localparam int unsigned TACH_CYCLES = (TACH_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned TACH_CNT_W = 20;
  localparam int unsigned BLANK_TICKS = 2;
  localparam int unsigned LOCK_TICKS = 2;

  // ------------------------------------------------------------
  // register map, word aligned byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] TACH_WIDTH_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] ID_OFFSET = 8'h0c;

  // control fields
  localparam int unsigned CTRL_SW_COAST_BIT = 0;
  localparam int unsigned CTRL_SW_BRAKE_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // status fields
  localparam int unsigned ST_POS_LSB = 0;
  localparam int unsigned ST_BLANK_HALL_LSB = 3;
  localparam int unsigned ST_TACH_BIT = 6;
  localparam int unsigned ST_SOFT_START_BIT = 7;
  localparam int unsigned ST_PWM_LATCH_BIT = 8;
  localparam int unsigned ST_LOW_DRIVE_LSB = 9;
  localparam int unsigned ST_HIGH_DRIVE_LSB = 12;
  localparam int unsigned ST_HIGH_PIN_LSB = 15;
  localparam int unsigned ST_BLANKING_BIT = 18;
  localparam int unsigned ST_BRAKE_BIT = 19;

  // arbitrary identification value
  localparam logic [31:0] ID_VALUE = 32'h0000_b1dc;

  // ------------------------------------------------------------
  // bus handshake states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bcp_bus_state_type;

endpackage : bcp_pkg

// ### logic/bcp_interlock.sv
// one cross-conduction interlock stage for a single drive signal
`timescale 1ns/1ps
module bcp_interlock #(
  parameter int unsigned HOLD_TICKS = 2
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic osc_tick,
  input wire logic drive_req,
  input wire logic opposing_flag,
  output logic drive_on,
  output logic lock_flag
);
  import bcp_pkg::*;

  initial begin
    if (HOLD_TICKS < 1 || HOLD_TICKS > 3) begin
      $error("hold ticks out of range");
    end
  end

  logic [1:0] hold_cnt_reg;
  logic drive_next;

  assign drive_next = drive_req & ~opposing_flag;

  // ------------------------------------------------------------
  // drive flip-flop
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      drive_on <= 1'b0;
    end else begin
      drive_on <= drive_next;
    end
  end

  // ------------------------------------------------------------
  // lock flag: set on turn-on, cleared after hold ticks off
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lock_flag <= 1'b0;
      hold_cnt_reg <= 2'h0;
    end else if (drive_next) begin
      lock_flag <= 1'b1;
      hold_cnt_reg <= 2'(HOLD_TICKS);
    end else if (lock_flag && !drive_on && osc_tick) begin
      if (hold_cnt_reg == 2'h1) begin
        lock_flag <= 1'b0;
      end
      hold_cnt_reg <= hold_cnt_reg - 2'h1;
    end
  end

endmodule : bcp_interlock

// ### logic/bcp_core.sv
// brushless motor commutation, chopping and protection core with wishbone registers
`timescale 1ns/1ps
module bcp_core #(
  parameter int unsigned TACH_DEFAULT = bcp_pkg::TACH_CYCLES
) (
  input wire logic sys_clk,
  input wire logic nrst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // sensors and analogue status
  input wire logic hall_sensor_a,
  input wire logic hall_sensor_b,
  input wire logic hall_sensor_c,
  input wire logic dir_in,
  input wire logic quad_sel_in,
  input wire logic brake_below_threshold,
  input wire logic overvoltage_freewheel_in,
  input wire logic uvlo_flag,
  input wire logic over_current_trip,
  input wire logic peak_current_trip,
  input wire logic pwm_comp_trip,
  input wire logic pwm_osc_tick,
  input wire logic soft_start_discharged,
  // gate drives
  output logic low_drive_phase_a,
  output logic low_drive_phase_b,
  output logic low_drive_phase_c,
  input wire logic high_drive_phase_a_n_in,
  output logic high_drive_phase_a_n_out,
  output logic high_drive_phase_a_n_oe,
  input wire logic high_drive_phase_b_n_in,
  output logic high_drive_phase_b_n_out,
  output logic high_drive_phase_b_n_oe,
  input wire logic high_drive_phase_c_n_in,
  output logic high_drive_phase_c_n_out,
  output logic high_drive_phase_c_n_oe,
  output logic tach_out,
  output logic soft_start_pin_out,
  output logic soft_start_pin_oe
);
  import bcp_pkg::*;

  initial begin
    if (TACH_DEFAULT < 1 || TACH_DEFAULT >= (1 << TACH_CNT_W)) begin
      $error("tach default out of range");
    end
  end

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  bcp_bus_state_type bus_state_reg;
  logic [1:0] ctrl_reg;
  logic [TACH_CNT_W-1:0] tach_width_reg;
  logic [2:0] hall_in;
  logic [2:0] blank_hall_reg;
  logic [1:0] blank_cnt_reg;
  logic blanking;
  logic [2:0] pos_reg;
  logic [TACH_CNT_W-1:0] tach_cnt_reg;
  logic tach_active_reg;
  logic soft_start_reg;
  logic pwm_latch_reg;
  logic brake_on;
  logic coast_on;
  logic kill;
  logic [2:0] low_sel;
  logic [2:0] high_sel;
  logic [2:0] low_req;
  logic [2:0] high_req;
  logic [2:0] low_on;
  logic [2:0] high_on;
  logic [2:0] low_flag;
  logic [2:0] high_flag;
  logic [2:0] high_pin;
  logic [31:0] status_word;
  logic [31:0] read_word;
  logic bus_req;
  logic bus_write;

  assign hall_in = {hall_sensor_c, hall_sensor_b, hall_sensor_a};
  assign high_pin = {high_drive_phase_c_n_in, high_drive_phase_b_n_in, high_drive_phase_a_n_in};
  assign brake_on = brake_below_threshold | ctrl_reg[CTRL_SW_BRAKE_BIT];
  assign coast_on = overvoltage_freewheel_in | ctrl_reg[CTRL_SW_COAST_BIT];
  assign kill = uvlo_flag | coast_on | over_current_trip;
  assign blanking = blank_cnt_reg != 2'h0;

  // ------------------------------------------------------------
  // wishbone slave
  // ------------------------------------------------------------
  assign bus_req = wb_cyc_i & wb_stb_i & (bus_state_reg == BUS_IDLE);
  assign bus_write = bus_req & wb_we_i;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bus_state_reg <= BUS_IDLE;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      unique case (bus_state_reg)
        BUS_IDLE: begin
          wb_ack_o <= bus_req;
          wb_dat_o <= bus_req ? read_word : 32'h0;
          if (bus_req) begin
            bus_state_reg <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          wb_ack_o <= 1'b0;
          wb_dat_o <= 32'h0;
          bus_state_reg <= BUS_IDLE;
        end
        default: begin
          wb_ack_o <= 1'b0;
          bus_state_reg <= BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= CTRL_RESET;
    end else if (bus_write && wb_adr_i == CTRL_OFFSET && wb_sel_i[0]) begin
      ctrl_reg <= wb_dat_i[1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tach_width_reg <= TACH_CNT_W'(TACH_DEFAULT);
    end else if (bus_write && wb_adr_i == TACH_WIDTH_OFFSET) begin
      if (wb_sel_i[0]) begin
        tach_width_reg[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        tach_width_reg[15:8] <= wb_dat_i[15:8];
      end
      if (wb_sel_i[2]) begin
        tach_width_reg[19:16] <= wb_dat_i[19:16];
      end
    end
  end

  always_comb begin
    status_word = 32'h0;
    status_word[ST_POS_LSB +: 3] = pos_reg;
    status_word[ST_BLANK_HALL_LSB +: 3] = blank_hall_reg;
    status_word[ST_TACH_BIT] = tach_out;
    status_word[ST_SOFT_START_BIT] = soft_start_reg;
    status_word[ST_PWM_LATCH_BIT] = pwm_latch_reg;
    status_word[ST_LOW_DRIVE_LSB +: 3] = low_on;
    status_word[ST_HIGH_DRIVE_LSB +: 3] = high_on;
    status_word[ST_HIGH_PIN_LSB +: 3] = high_pin;
    status_word[ST_BLANKING_BIT] = blanking;
    status_word[ST_BRAKE_BIT] = brake_on;
  end

  always_comb begin
    unique case (wb_adr_i)
      CTRL_OFFSET: read_word = {30'h0, ctrl_reg};
      TACH_WIDTH_OFFSET: read_word = {12'h0, tach_width_reg};
      STATUS_OFFSET: read_word = status_word;
      ID_OFFSET: read_word = ID_VALUE;
      default: read_word = 32'h0;
    endcase
  end

  // ------------------------------------------------------------
  // hall blanking latches
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      blank_hall_reg <= 3'h0;
      blank_cnt_reg <= 2'h0;
    end else if (!blanking) begin
      if (hall_in != blank_hall_reg) begin
        blank_hall_reg <= hall_in;
        blank_cnt_reg <= 2'(BLANK_TICKS);
      end
    end else if (pwm_osc_tick) begin
      blank_cnt_reg <= blank_cnt_reg - 2'h1;
    end
  end

  // ------------------------------------------------------------
  // position latches and tachometer pulse
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pos_reg <= 3'h0;
      tach_cnt_reg <= '0;
      tach_active_reg <= 1'b0;
    end else if (!tach_active_reg && blank_hall_reg != pos_reg) begin
      pos_reg <= blank_hall_reg;
      tach_cnt_reg <= tach_width_reg;
      tach_active_reg <= tach_width_reg != '0;
    end else if (tach_active_reg) begin
      tach_cnt_reg <= tach_cnt_reg - TACH_CNT_W'(1);
      if (tach_cnt_reg == TACH_CNT_W'(1)) begin
        tach_active_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tach_out <= 1'b0;
    end else begin
      tach_out <= (tach_active_reg | (!tach_active_reg && blank_hall_reg != pos_reg
                   && tach_width_reg != '0)) & ~brake_on;
    end
  end

  // ------------------------------------------------------------
  // soft-start latch
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      soft_start_reg <= 1'b1;
    end else if (uvlo_flag || over_current_trip) begin
      soft_start_reg <= 1'b1;
    end else if (soft_start_discharged) begin
      soft_start_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      soft_start_pin_out <= 1'b0;
      soft_start_pin_oe <= 1'b1;
    end else begin
      soft_start_pin_out <= 1'b0;
      soft_start_pin_oe <= (soft_start_reg & ~soft_start_discharged) | uvlo_flag | over_current_trip
                           | (soft_start_reg & soft_start_discharged);
    end
  end

  // ------------------------------------------------------------
  // pwm latch
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pwm_latch_reg <= 1'b0;
    end else if (pwm_comp_trip || peak_current_trip) begin
      pwm_latch_reg <= 1'b0;
    end else if (pwm_osc_tick) begin
      pwm_latch_reg <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // commutation decode, bit 0 phase a
  // ------------------------------------------------------------
  always_comb begin
    low_sel = 3'h0;
    high_sel = 3'h0;
    unique case (pos_reg)
      3'h1: begin
        low_sel = 3'h2;
        high_sel = 3'h1;
      end
      3'h3: begin
        low_sel = 3'h4;
        high_sel = 3'h1;
      end
      3'h2: begin
        low_sel = 3'h4;
        high_sel = 3'h2;
      end
      3'h6: begin
        low_sel = 3'h1;
        high_sel = 3'h2;
      end
      3'h4: begin
        low_sel = 3'h1;
        high_sel = 3'h4;
      end
      3'h5: begin
        low_sel = 3'h2;
        high_sel = 3'h4;
      end
      default: begin
        low_sel = 3'h0;
        high_sel = 3'h0;
      end
    endcase
    if (!dir_in) begin
      {low_sel, high_sel} = {high_sel, low_sel};
    end
  end

  // ------------------------------------------------------------
  // chopping, brake and kill
  // ------------------------------------------------------------
  always_comb begin
    if (kill) begin
      low_req = 3'h0;
      high_req = 3'h0;
    end else if (brake_on) begin
      low_req = {3{pwm_latch_reg}};
      high_req = 3'h0;
    end else if (quad_sel_in) begin
      low_req = low_sel & {3{pwm_latch_reg}};
      high_req = high_sel & {3{pwm_latch_reg}};
    end else begin
      low_req = low_sel & {3{pwm_latch_reg}};
      high_req = high_sel;
    end
  end

  // ------------------------------------------------------------
  // interlock stages
  // ------------------------------------------------------------
  genvar ph;
  generate
    for (ph = 0; ph < 3; ph++) begin : g_phase
      bcp_interlock #(
        .HOLD_TICKS(LOCK_TICKS)
      ) u_low (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .osc_tick(pwm_osc_tick),
        .drive_req(low_req[ph] & ~high_req[ph]),
        .opposing_flag(high_flag[ph]),
        .drive_on(low_on[ph]),
        .lock_flag(low_flag[ph])
      );
      bcp_interlock #(
        .HOLD_TICKS(LOCK_TICKS)
      ) u_high (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .osc_tick(pwm_osc_tick),
        .drive_req(high_req[ph]),
        .opposing_flag(low_flag[ph]),
        .drive_on(high_on[ph]),
        .lock_flag(high_flag[ph])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------
  always_comb begin
    low_drive_phase_a = low_on[0];
    low_drive_phase_b = low_on[1];
    low_drive_phase_c = low_on[2];
    high_drive_phase_a_n_out = 1'b0;
    high_drive_phase_b_n_out = 1'b0;
    high_drive_phase_c_n_out = 1'b0;
    high_drive_phase_a_n_oe = high_on[0];
    high_drive_phase_b_n_oe = high_on[1];
    high_drive_phase_c_n_oe = high_on[2];
  end

endmodule : bcp_core

// ### sim/bcp_core_assertions.sv
// checker watching the drive, tach and soft-start ports of the core
`timescale 1ns/1ps
module bcp_core_checker #(
  parameter int unsigned TACH_DEFAULT = 4
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic brake_below_threshold,
  input wire logic overvoltage_freewheel_in,
  input wire logic uvlo_flag,
  input wire logic over_current_trip,
  input wire logic pwm_osc_tick,
  input wire logic soft_start_discharged,
  input wire logic low_drive_phase_a,
  input wire logic low_drive_phase_b,
  input wire logic low_drive_phase_c,
  input wire logic high_drive_phase_a_n_oe,
  input wire logic high_drive_phase_b_n_oe,
  input wire logic high_drive_phase_c_n_oe,
  input wire logic tach_out,
  input wire logic soft_start_pin_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [2:0] low_on;
  logic [2:0] high_on;
  logic [1:0] off_ticks_reg;
  logic [19:0] tach_len_reg;
  assign low_on = {low_drive_phase_c, low_drive_phase_b, low_drive_phase_a};
  assign high_on = {high_drive_phase_c_n_oe, high_drive_phase_b_n_oe, high_drive_phase_a_n_oe};
  // ------------------------------------------------------------
  // helper counters
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) off_ticks_reg <= 2'h3;
    else if (low_drive_phase_a) off_ticks_reg <= 2'h0;
    else if (pwm_osc_tick && off_ticks_reg != 2'h3) off_ticks_reg <= off_ticks_reg + 2'h1;
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) tach_len_reg <= 20'h0;
    else if (tach_out) tach_len_reg <= tach_len_reg + 20'h1;
    else tach_len_reg <= 20'h0;
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_no_overlap: assert property ((low_on & high_on) == 3'h0)
    else $error("low and high drive of one phase on together");
  a_dead_time: assert property ($rose(high_drive_phase_a_n_oe) |-> off_ticks_reg >= 2'h2)
    else $error("high drive a on within two ticks of low drive a off");
  a_uvlo_off: assert property (uvlo_flag [*4] |-> (low_on | high_on) == 3'h0)
    else $error("drive on during undervoltage");
  a_coast_off: assert property (overvoltage_freewheel_in [*4] |-> (low_on | high_on) == 3'h0)
    else $error("drive on during coast");
  a_brake_high_off: assert property (brake_below_threshold [*4] |-> high_on == 3'h0)
    else $error("high drive on during brake");
  a_brake_no_tach: assert property (brake_below_threshold [*5] |-> !$rose(tach_out))
    else $error("tach pulse during brake");
  a_soft_start_set: assert property ((uvlo_flag || over_current_trip) |-> ##[1:2] soft_start_pin_oe)
    else $error("soft-start pull-down not on after fault");
  a_soft_start_clear: assert property ($fell(soft_start_pin_oe)
    |-> $past(soft_start_discharged) || $past(soft_start_discharged, 2))
    else $error("soft-start released before discharge");
  // pulse spans the capture cycle plus the programmed width
  a_tach_width: assert property ($fell(tach_out) |-> tach_len_reg == 20'(TACH_DEFAULT + 1))
    else $error("tach pulse width wrong");
endmodule : bcp_core_checker

bind bcp_core bcp_core_checker #(.TACH_DEFAULT(TACH_DEFAULT)) u_checker (
  .sys_clk(sys_clk), .nrst(nrst), .brake_below_threshold(brake_below_threshold),
  .overvoltage_freewheel_in(overvoltage_freewheel_in), .uvlo_flag(uvlo_flag),
  .over_current_trip(over_current_trip), .pwm_osc_tick(pwm_osc_tick),
  .soft_start_discharged(soft_start_discharged), .low_drive_phase_a(low_drive_phase_a),
  .low_drive_phase_b(low_drive_phase_b), .low_drive_phase_c(low_drive_phase_c),
  .high_drive_phase_a_n_oe(high_drive_phase_a_n_oe), .high_drive_phase_b_n_oe(high_drive_phase_b_n_oe),
  .high_drive_phase_c_n_oe(high_drive_phase_c_n_oe), .tach_out(tach_out),
  .soft_start_pin_oe(soft_start_pin_oe)
);

// ### sim/bcp_bridge_model.sv
// power bridge model: high-side pull-ups and soft-start capacitor
`timescale 1ns/1ps
module bcp_bridge_model #(
  parameter int unsigned DISCH_CYCLES = 6
) (
  input wire logic sys_clk,
  input wire logic [2:0] low_on,
  input wire logic [2:0] high_oe,
  input wire logic ss_oe,
  output logic [2:0] high_pin,
  output logic ss_discharged,
  output logic shoot_thru
);
  int unsigned cap_level_reg = DISCH_CYCLES;
  // released open-collector pin is pulled up by the level shifter
  assign high_pin = ~high_oe;
  // both devices of a phase on shorts the supply
  assign shoot_thru = |(low_on & high_oe);
  always @(posedge sys_clk) begin
    if (ss_oe && cap_level_reg != 0) cap_level_reg <= cap_level_reg - 1;
    else if (!ss_oe && cap_level_reg < DISCH_CYCLES) cap_level_reg <= cap_level_reg + 1;
  end
  // comparator sees the capacitor fully discharged
  assign ss_discharged = (cap_level_reg == 0);
endmodule : bcp_bridge_model

// ### sim/tb_bldc_commutation_protection.sv
// self-checking bench for the motor commutation and protection core
`timescale 1ns/1ps
module tb_bldc_commutation_protection;
  import bcp_pkg::*;
  localparam int unsigned TW = 4;
  logic sys_clk;
  logic nrst;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [2:0] hall;
  logic dir_in;
  logic quad_sel_in;
  logic brake;
  logic coast;
  logic uvlo_flag;
  logic over_current_trip;
  logic peak_current_trip;
  logic pwm_comp_trip;
  logic pwm_osc_tick = 1'b0;
  logic ss_dis;
  logic [2:0] lows;
  logic [2:0] hoe;
  logic [2:0] hout;
  logic [2:0] hpin;
  logic tach_out;
  logic ss_out;
  logic ss_oe;
  logic shoot;
  logic tach_q;
  logic [2:0] tick_cnt = 3'h0;
  logic [31:0] rd;
  logic [31:0] r;
  logic [31:0] seed;
  logic [2:0] seq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  int n_fail = 0;
  int num_checks = 0;
  int n_tach = 0;
  int n_shoot = 0;
  int cyc_cnt = 0;
  int t;

  bcp_core #(.TACH_DEFAULT(TW)) DUT (
    .sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .hall_sensor_a(hall[0]), .hall_sensor_b(hall[1]), .hall_sensor_c(hall[2]), .dir_in(dir_in),
    .quad_sel_in(quad_sel_in), .brake_below_threshold(brake), .overvoltage_freewheel_in(coast),
    .uvlo_flag(uvlo_flag), .over_current_trip(over_current_trip), .peak_current_trip(peak_current_trip),
    .pwm_comp_trip(pwm_comp_trip), .pwm_osc_tick(pwm_osc_tick), .soft_start_discharged(ss_dis),
    .low_drive_phase_a(lows[0]), .low_drive_phase_b(lows[1]), .low_drive_phase_c(lows[2]),
    .high_drive_phase_a_n_in(hpin[0]), .high_drive_phase_a_n_out(hout[0]), .high_drive_phase_a_n_oe(hoe[0]),
    .high_drive_phase_b_n_in(hpin[1]), .high_drive_phase_b_n_out(hout[1]), .high_drive_phase_b_n_oe(hoe[1]),
    .high_drive_phase_c_n_in(hpin[2]), .high_drive_phase_c_n_out(hout[2]), .high_drive_phase_c_n_oe(hoe[2]),
    .tach_out(tach_out), .soft_start_pin_out(ss_out), .soft_start_pin_oe(ss_oe)
  );
  bcp_bridge_model u_bridge (
    .sys_clk(sys_clk), .low_on(lows), .high_oe(hoe), .ss_oe(ss_oe),
    .high_pin(hpin), .ss_discharged(ss_dis), .shoot_thru(shoot)
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // oscillator tick every eight clocks, tach and overlap monitors, run limit
  always @(posedge sys_clk) begin
    tick_cnt <= tick_cnt + 3'h1;
    pwm_osc_tick <= (tick_cnt == 3'h7);
    cyc_cnt++;
    if (tach_out === 1'b1 && tach_q !== 1'b1) n_tach++;
    tach_q <= tach_out;
    if (shoot !== 1'b0) n_shoot++;
    if (cyc_cnt == 30000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  // ------------------------------------------------------------
  // tasks and functions
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wait_cyc
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    @(posedge sys_clk);
    while (wb_ack_o !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 100) chk("wb_ack", 1'b1, wb_ack_o);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge sys_clk);
  endtask : wb_xfer
  task automatic wait_ss(input logic lvl);
    int n;
    n = 0;
    while (ss_oe !== lvl && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    chk("soft_start_pin_oe", lvl, ss_oe);
  endtask : wait_ss
  function automatic logic pair_ok(input logic [2:0] lo, input logic [2:0] hi);
    return $countones(lo) == 1 && $countones(hi) == 1 && (lo & hi) == 3'h0;
  endfunction : pair_ok
  function automatic logic [31:0] tach_exp(input logic [31:0] v);
    return v & 32'h000f_ffff;
  endfunction : tach_exp
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'hca559dea;
    nrst = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    hall = 3'h1;
    dir_in = 1'b1;
    quad_sel_in = 1'b0;
    brake = 1'b0;
    coast = 1'b0;
    uvlo_flag = 1'b0;
    over_current_trip = 1'b0;
    peak_current_trip = 1'b0;
    pwm_comp_trip = 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    wb_xfer(1'b0, ID_OFFSET, 32'h0, rd);
    chk("id", ID_VALUE, rd);
    wb_xfer(1'b0, CTRL_OFFSET, 32'h0, rd);
    chk("ctrl_reset", 32'h0, rd);
    wb_xfer(1'b0, TACH_WIDTH_OFFSET, 32'h0, rd);
    chk("tach_reset", TW, rd);
    wb_xfer(1'b0, 8'h10, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    r = $random(seed);
    wb_xfer(1'b1, TACH_WIDTH_OFFSET, r, rd);
    wb_xfer(1'b0, TACH_WIDTH_OFFSET, 32'h0, rd);
    chk("tach_rw", tach_exp(r), rd);
    wb_xfer(1'b1, TACH_WIDTH_OFFSET, TW, rd);
    wb_xfer(1'b1, ID_OFFSET, r, rd);
    wb_xfer(1'b0, ID_OFFSET, 32'h0, rd);
    chk("id_ro", ID_VALUE, rd);
    wait_ss(1'b0);
    $display("test registers done");
    for (int d = 1; d >= 0; d--) begin
      dir_in <= d[0];
      wait_cyc(48);
      for (int i = 0; i < 6; i++) begin
        t = n_tach;
        r = $random(seed);
        hall <= seq[(i + 1) % 6];
        quad_sel_in <= r[1];
        wait_cyc(48);
        chk("tach_pulses", t + 1, n_tach);
        chk("drive_pair", 1'b1, pair_ok(lows, hoe));
        chk("high_pin_out", 3'h0, hout);
        wb_xfer(1'b0, STATUS_OFFSET, 32'h0, rd);
        chk("status_pos", {29'h0, hall}, {29'h0, rd[2:0]});
        pwm_comp_trip <= 1'b1;
        wait_cyc(4);
        chk("low_chopped", 3'h0, lows);
        chk("high_chopped", quad_sel_in ? 0 : 1, $countones(hoe));
        pwm_comp_trip <= 1'b0;
        wait_cyc(24);
      end
    end
    $display("test rotation done");
    t = n_tach;
    brake <= 1'b1;
    hall <= seq[1];
    for (int q = 0; q < 2; q++) begin
      quad_sel_in <= q[0];
      wait_cyc(40);
      chk("brake_drives", 6'h07, {hoe, lows});
      pwm_comp_trip <= 1'b1;
      wait_cyc(4);
      chk("brake_comp", 3'h0, lows);
      pwm_comp_trip <= 1'b0;
    end
    wait_cyc(40);
    peak_current_trip <= 1'b1;
    wait_cyc(4);
    chk("brake_peak", 3'h0, lows);
    peak_current_trip <= 1'b0;
    chk("brake_tach", t, n_tach);
    brake <= 1'b0;
    coast <= 1'b1;
    wait_cyc(6);
    chk("coast_pin", 6'h0, {hoe, lows});
    coast <= 1'b0;
    wb_xfer(1'b1, CTRL_OFFSET, 32'h1, rd);
    wait_cyc(6);
    chk("coast_sw", 6'h0, {hoe, lows});
    wb_xfer(1'b0, CTRL_OFFSET, 32'h0, rd);
    chk("ctrl_rw", 32'h1, rd);
    wb_xfer(1'b1, CTRL_OFFSET, 32'h2, rd);
    wait_cyc(40);
    chk("brake_sw", 6'h07, {hoe, lows});
    wb_xfer(1'b1, CTRL_OFFSET, 32'h0, rd);
    $display("test brake and coast done");
    over_current_trip <= 1'b1;
    wait_cyc(3);
    chk("oc_soft_start", 1'b1, ss_oe);
    chk("ss_pin_out", 1'b0, ss_out);
    over_current_trip <= 1'b0;
    wait_ss(1'b0);
    uvlo_flag <= 1'b1;
    wait_cyc(20);
    chk("uvlo_soft_start", 1'b1, ss_oe);
    chk("uvlo_drives", 6'h0, {hoe, lows});
    uvlo_flag <= 1'b0;
    wait_ss(1'b0);
    wait_cyc(48);
    chk("recover_pair", 1'b1, pair_ok(lows, hoe));
    chk("shoot_through", 0, n_shoot);
    $display("test faults done");
    tally_and_finish();
  end
endmodule : tb_bldc_commutation_protection
